/* core/dual_port_block_mem.sv */
// Purpose: true dual-port block memory with select decode, write policies,
//          output pipeline, reset style, power-on content and a small rom
// Assumes: one clock; user logic guards same-address collisions itself
// Notes:   rom output stage shares the core clock; its gate acts as enable
// What this block does
// - rom offers optional registered output stage
// - rom register uses output clock gate
// - every bit has configurable power-on value
// - row content maps rows to addresses in order
// - addressed content loads consecutive words from start
// - unspecified locations power up as zero
// - word width parameter sets stored bits
// - output mode selects optional pipeline register
// - reset style selects synchronous or asynchronous for port outputs; rom register memory reset is always synchronous
// - 3-bit select must equal match value
// - each port holds its own match value
// - normal policy keeps output during write
// - forward policy shows write data
// - old-data policy shows prior content, widths 9/18/36
// - write policy configurable per port
// - read during other port write is unknown
// - double write with differing bits undetermined
// - global set/reset effect is configurable for port outputs; rom register always clears on i_rstn
`default_nettype none
module dual_port_block_mem
  import mem_cfg_pkg::*;
#(
  parameter logic [SEL_W-1:0]         port_a_select_match = 3'h0,
  parameter logic [SEL_W-1:0]         port_b_select_match = 3'h0,
  parameter write_output_policy_t     port_a_write_policy = normal_policy,
  parameter write_output_policy_t     port_b_write_policy = normal_policy,
  parameter output_pipeline_mode_t    output_pipeline_mode = unregistered_output,
  parameter reset_style_t             reset_style = reset_sync,
  parameter logic                     global_set_reset_enable = 1'b1,
  parameter output_pipeline_mode_t    rom_pipeline_mode = unregistered_output,
  parameter logic [DEPTH*DATA_W-1:0]  ram_init = '0,
  parameter logic [DEPTH*ROM_W-1:0]   rom_init = '0
)(
  input  wire logic              i_ref_clk,
  input  wire logic              i_rstn,
  input  wire logic              i_clk_en,
  input  wire logic              i_mem_rst,
  input  wire port_req_t         i_port_a,
  input  wire port_req_t         i_port_b,
  input  wire logic [ADDR_W-1:0] i_rom_addr,
  input  wire logic              i_rom_output_clock_gate,
  output logic [DATA_W-1:0]      o_port_a_q,
  output logic [DATA_W-1:0]      o_port_b_q,
  output logic [ROM_W-1:0]       o_rom_q
);

  // power-on content: packed word i holds address i; unset words stay zero
  logic [DATA_W-1:0] mem_r [DEPTH];
  logic [ROM_W-1:0]  rom   [DEPTH];

  initial
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      mem_r[i] = ram_init[i*DATA_W +: DATA_W];
      rom[i]   = rom_init[i*ROM_W +: ROM_W];
    end
  end

  function automatic logic port_hit(input port_req_t p, input logic [SEL_W-1:0] m);
    port_hit = p.en && (p.sel == m);
  endfunction

  logic hit_a;
  logic hit_b;
  logic wr_a;
  logic wr_b;
  logic gsr_rst;

  always_comb
  begin
    hit_a = i_clk_en && port_hit(i_port_a, port_a_select_match);
    hit_b = i_clk_en && port_hit(i_port_b, port_b_select_match);
    wr_a  = hit_a && i_port_a.we;
    wr_b  = hit_b && i_port_b.we;
    gsr_rst = global_set_reset_enable && !i_rstn;
  end

  // array writes: port b last, so b wins a double write; the result is
  // undetermined anyway and users must keep the ports apart
  always_ff @(posedge i_ref_clk)
  begin
    if (wr_a)
      mem_r[i_port_a.addr] <= i_port_a.wdata;
    if (wr_b)
      mem_r[i_port_b.addr] <= i_port_b.wdata;
  end

  function automatic logic [DATA_W-1:0] port_out(
    input port_req_t p, input logic hit, input write_output_policy_t pol,
    input logic [DATA_W-1:0] stored, input logic [DATA_W-1:0] prev);
    port_out = prev;
    if (hit && !p.we)
      port_out = stored;
    else if (hit && p.we)
    begin
      case (pol)
        normal_policy:            port_out = prev;
        write_forward_policy:     port_out = p.wdata;
        old_data_on_write_policy: port_out = stored;
        default:                  port_out = prev;
      endcase
    end
  endfunction

  logic [DATA_W-1:0] lat_a_r;
  logic [DATA_W-1:0] lat_b_r;
  logic [DATA_W-1:0] pipe_a_r;
  logic [DATA_W-1:0] pipe_b_r;
  logic [DATA_W-1:0] lat_a_nxt;
  logic [DATA_W-1:0] lat_b_nxt;
  logic [DATA_W-1:0] pipe_a_nxt;
  logic [DATA_W-1:0] pipe_b_nxt;
  logic              sync_clr;

  always_comb
  begin
    // cross-port same-address read during write returns stored data here;
    // callers must treat it as unknown
    lat_a_nxt  = port_out(i_port_a, hit_a, port_a_write_policy,
                          mem_r[i_port_a.addr], lat_a_r);
    lat_b_nxt  = port_out(i_port_b, hit_b, port_b_write_policy,
                          mem_r[i_port_b.addr], lat_b_r);
    pipe_a_nxt = i_clk_en ? lat_a_r : pipe_a_r;
    pipe_b_nxt = i_clk_en ? lat_b_r : pipe_b_r;
    sync_clr   = (reset_style == reset_sync) && i_mem_rst;
    if (sync_clr)
    begin
      lat_a_nxt  = ZERO_WORD;
      lat_b_nxt  = ZERO_WORD;
      pipe_a_nxt = ZERO_WORD;
      pipe_b_nxt = ZERO_WORD;
    end
  end

  // async style clears on the memory reset without waiting for the clock
  logic async_clr_n;
  assign async_clr_n = !(gsr_rst || ((reset_style == reset_async) && i_mem_rst));

  always_ff @(posedge i_ref_clk or negedge async_clr_n)
  begin
    if (!async_clr_n)
    begin
      lat_a_r  <= ZERO_WORD;
      lat_b_r  <= ZERO_WORD;
      pipe_a_r <= ZERO_WORD;
      pipe_b_r <= ZERO_WORD;
    end
    else
    begin
      lat_a_r  <= lat_a_nxt;
      lat_b_r  <= lat_b_nxt;
      pipe_a_r <= pipe_a_nxt;
      pipe_b_r <= pipe_b_nxt;
    end
  end

  always_comb
  begin
    o_port_a_q = (output_pipeline_mode == registered_output) ? pipe_a_r : lat_a_r;
    o_port_b_q = (output_pipeline_mode == registered_output) ? pipe_b_r : lat_b_r;
  end

  // rom: combinational read, optional register gated by its output gate
  logic [ROM_W-1:0] rom_q_r;
  logic [ROM_W-1:0] rom_q_nxt;

  always_comb
  begin
    rom_q_nxt = rom_q_r;
    // the core clock enable freezes this register as well as the gate
    if (i_clk_en && i_rom_output_clock_gate)
      rom_q_nxt = rom[i_rom_addr];
    if (i_mem_rst)
      rom_q_nxt = ZERO_ROM;
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      rom_q_r <= ZERO_ROM;
    else
      rom_q_r <= rom_q_nxt;
  end

  assign o_rom_q = (rom_pipeline_mode == registered_output) ? rom_q_r
                                                            : rom[i_rom_addr];

  // checks
  // same-address cross-port cases are the user logic's duty; only write_store_a
  // excludes them, and the read checks still compare old stored data while the other port writes

  // array stores
  write_store_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    wr_a && !(wr_b && i_port_b.addr == i_port_a.addr)
      |=> mem_r[$past(i_port_a.addr)] == $past(i_port_a.wdata))
    else $error("port a write not stored");
  write_store_b: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    wr_b
      |=> mem_r[$past(i_port_b.addr)] == $past(i_port_b.wdata))
    else $error("port b write not stored");

  // select decode and clock enable
  select_miss_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    i_port_a.sel != port_a_select_match && !i_mem_rst
      |=> $stable(lat_a_r))
    else $error("port a moved on select mismatch");
  select_miss_b: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    i_port_b.sel != port_b_select_match && !i_mem_rst
      |=> $stable(lat_b_r))
    else $error("port b moved on select mismatch");
  clk_en_hold_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    !i_clk_en && !i_mem_rst
      |=> $stable(lat_a_r))
    else $error("port a moved with clock enable low");
  clk_en_hold_b: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    !i_clk_en && !i_mem_rst
      |=> $stable(lat_b_r))
    else $error("port b moved with clock enable low");

  // reads
  read_data_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    hit_a && !i_port_a.we && !i_mem_rst
      |=> lat_a_r == $past(mem_r[i_port_a.addr]))
    else $error("port a read data wrong");
  read_data_b: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    hit_b && !i_port_b.we && !i_mem_rst
      |=> lat_b_r == $past(mem_r[i_port_b.addr]))
    else $error("port b read data wrong");

  // write output policies, one set per port
  normal_hold_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    port_a_write_policy == normal_policy && wr_a && !i_mem_rst
      |=> $stable(lat_a_r))
    else $error("normal policy output changed on write");
  normal_hold_b: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    port_b_write_policy == normal_policy && wr_b && !i_mem_rst
      |=> $stable(lat_b_r))
    else $error("normal policy output changed on write");
  forward_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    port_a_write_policy == write_forward_policy && wr_a && !i_mem_rst
      |=> lat_a_r == $past(i_port_a.wdata))
    else $error("forward policy output wrong");
  forward_b: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    port_b_write_policy == write_forward_policy && wr_b && !i_mem_rst
      |=> lat_b_r == $past(i_port_b.wdata))
    else $error("forward policy output wrong");
  old_data_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    port_a_write_policy == old_data_on_write_policy && wr_a && !i_mem_rst
      |=> lat_a_r == $past(mem_r[i_port_a.addr]))
    else $error("old data policy output wrong");
  old_data_b: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    port_b_write_policy == old_data_on_write_policy && wr_b && !i_mem_rst
      |=> lat_b_r == $past(mem_r[i_port_b.addr]))
    else $error("old data policy output wrong");
  old_width_ok_a: assert property (
    @(posedge i_ref_clk)
    old_data_width_ok(DATA_W) || (port_a_write_policy != old_data_on_write_policy
      && port_b_write_policy != old_data_on_write_policy))
    else $error("old data policy on unsupported width");

  // output pipeline and reset style
  pipe_delay_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    output_pipeline_mode == registered_output && i_clk_en && !i_mem_rst
      |=> o_port_a_q == $past(lat_a_r))
    else $error("pipeline output not one cycle behind");
  pipe_delay_b: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    output_pipeline_mode == registered_output && i_clk_en && !i_mem_rst
      |=> o_port_b_q == $past(lat_b_r))
    else $error("pipeline output not one cycle behind");
  sync_reset_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    reset_style == reset_sync && i_mem_rst
      |=> lat_a_r == ZERO_WORD)
    else $error("sync reset did not clear output");
  sync_reset_b: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    reset_style == reset_sync && i_mem_rst
      |=> lat_b_r == ZERO_WORD)
    else $error("sync reset did not clear output");

  // rom output register
  rom_gate_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    !i_rom_output_clock_gate && !i_mem_rst
      |=> $stable(rom_q_r))
    else $error("rom register moved while gated");
  rom_load_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    i_clk_en && i_rom_output_clock_gate && !i_mem_rst
      |=> rom_q_r == $past(rom[i_rom_addr]))
    else $error("rom register did not load");
endmodule
`default_nettype wire

/* core/mem_cfg_pkg.sv */
// Purpose: shared constants and types for the configurable block memory
// Assumes: single clock, user logic drives ports on rising edges
// Notes:   widths fixed at the documented values
`default_nettype none
package mem_cfg_pkg;
  localparam int ADDR_W       = 4;
  localparam int DATA_W       = 9;
  localparam int DEPTH        = 16;
  localparam int SEL_W        = 3;
  localparam int ROM_W        = 8;
  localparam int INIT_FILL    = 0;
  localparam logic [DATA_W-1:0] ZERO_WORD = 9'h000;
  localparam logic [ROM_W-1:0]  ZERO_ROM  = 8'h00;

  typedef enum logic [1:0] {
    normal_policy,
    write_forward_policy,
    old_data_on_write_policy
  } write_output_policy_t;

  typedef enum logic {
    unregistered_output,
    registered_output
  } output_pipeline_mode_t;

  typedef enum logic {
    reset_sync,
    reset_async
  } reset_style_t;

  typedef struct packed {
    logic              en;
    logic              we;
    logic [SEL_W-1:0]  sel;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } port_req_t;

  // old-data policy exists only for 9, 18 and 36 bit words
  function automatic logic old_data_width_ok(input int w);
    old_data_width_ok = (w == 9) || (w == 18) || (w == 36);
  endfunction
endpackage
`default_nettype wire

/* sim/mem_user_model.sv */
// Purpose: user logic in front of the block memory, routing requests
// Assumes: bench issues one request at a time
// Notes:   cross-port same-address access is blocked, not flagged
`default_nettype none
module mem_user_model
  import mem_cfg_pkg::*;
(
  input  wire port_req_t  i_req,
  input  wire logic       i_to_b,
  output port_req_t       o_port_a,
  output port_req_t       o_port_b
);
  timeunit 1ns;
  timeprecision 1ps;
  port_req_t a_c;
  port_req_t b_c;
  always_comb
  begin
    a_c = i_to_b ? '0 : i_req;
    b_c = i_to_b ? i_req : '0;
    // b yields when both ports hit one address, so no read is ever suspect
    if (a_c.en && b_c.en && a_c.addr == b_c.addr) b_c.en = 1'b0;
  end
  assign o_port_a = a_c;
  assign o_port_b = b_c;
endmodule
`default_nettype wire

/* sim/dual_port_block_mem_tb.sv */
// Purpose: self-checking bench for the dual-port block memory
// Assumes: port a forwards writes, port b shows old data, rom registered
// Notes:   inputs change on rising edges by non-blocking assignment
`default_nettype none
module dual_port_block_mem_tb;
  import mem_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic              i_ref_clk = 1'b0;
  logic              i_rstn = 1'b0;
  logic              i_clk_en = 1'b1;
  logic              i_mem_rst = 1'b0;
  logic              to_b = 1'b0;
  port_req_t         req = '0;
  port_req_t         pa;
  port_req_t         pb;
  logic [ADDR_W-1:0] i_rom_addr = 4'h0;
  logic              i_rom_output_clock_gate = 1'b0;
  logic [DATA_W-1:0] qa;
  logic [DATA_W-1:0] qb;
  logic [ROM_W-1:0]  rq;
  int                fail_count = 0;
  int                n_compared = 0;
  always #10 i_ref_clk = ~i_ref_clk;
  mem_user_model i_mem_user_model (.i_req(req), .i_to_b(to_b), .o_port_a(pa), .o_port_b(pb));
  dual_port_block_mem #(
    .port_a_select_match(3'h5), .port_b_select_match(3'h2),
    .port_a_write_policy(write_forward_policy),
    .port_b_write_policy(old_data_on_write_policy),
    .rom_pipeline_mode(registered_output),
    .ram_init(144'h1a5 << 9), .rom_init(128'h3c << 16)
  ) i_dual_port_block_mem (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_clk_en(i_clk_en), .i_mem_rst(i_mem_rst),
    .i_port_a(pa), .i_port_b(pb), .i_rom_addr(i_rom_addr),
    .i_rom_output_clock_gate(i_rom_output_clock_gate),
    .o_port_a_q(qa), .o_port_b_q(qb), .o_rom_q(rq));
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // one access: driven after an edge, taken at the next, answer read just after it
  task automatic acc(input logic b, input logic w, input logic [2:0] s,
                     input logic [3:0] a, input logic [8:0] d);
    @(posedge i_ref_clk);
    to_b <= b;
    req <= '{en: 1'b1, we: w, sel: s, addr: a, wdata: d};
    @(posedge i_ref_clk);
    req <= '0;
    #1;
  endtask
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #20000;
    fail_count++;
    complete_run();
  end
  initial
  begin
    repeat (3) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    #1;
    chk(qa, 9'h000);
    acc(1'b0, 1'b0, 3'h5, 4'h1, 9'h000);
    chk(qa, 9'h1a5);
    acc(1'b1, 1'b0, 3'h2, 4'h2, 9'h000);
    chk(qb, 9'h000);
    acc(1'b0, 1'b1, 3'h5, 4'h3, 9'h0f0);
    chk(qa, 9'h0f0);
    acc(1'b1, 1'b1, 3'h2, 4'h3, 9'h111);
    chk(qb, 9'h0f0);
    acc(1'b0, 1'b0, 3'h5, 4'h3, 9'h000);
    chk(qa, 9'h111);
    acc(1'b0, 1'b1, 3'h2, 4'h4, 9'h0aa);
    chk(qa, 9'h111);
    acc(1'b1, 1'b1, 3'h5, 4'h4, 9'h0bb);
    acc(1'b1, 1'b0, 3'h2, 4'h4, 9'h000);
    chk(qb, 9'h000);
    @(posedge i_ref_clk);
    i_clk_en <= 1'b0;
    acc(1'b0, 1'b1, 3'h5, 4'h5, 9'h0cc);
    chk(qa, 9'h111);
    @(posedge i_ref_clk);
    i_clk_en <= 1'b1;
    acc(1'b0, 1'b0, 3'h5, 4'h5, 9'h000);
    chk(qa, 9'h000);
    acc(1'b0, 1'b0, 3'h5, 4'h1, 9'h000);
    chk(qa, 9'h1a5);
    @(posedge i_ref_clk);
    i_mem_rst <= 1'b1;
    @(posedge i_ref_clk);
    i_mem_rst <= 1'b0;
    i_rom_addr <= 4'h2;
    i_rom_output_clock_gate <= 1'b1;
    #1;
    chk(qa, 9'h000);
    @(posedge i_ref_clk);
    i_rom_output_clock_gate <= 1'b0;
    i_rom_addr <= 4'h1;
    #1;
    chk({1'b0, rq}, 9'h03c);
    @(posedge i_ref_clk);
    i_rom_output_clock_gate <= 1'b1;
    #1;
    chk({1'b0, rq}, 9'h03c);
    @(posedge i_ref_clk);
    #1;
    chk({1'b0, rq}, 9'h000);
    complete_run();
  end
endmodule
`default_nettype wire
